// ==== logic/dqr_dev_end.sv ====
/*
 * Flash-side command logic for dual and quad I/O reads with the
 * continuous-read (opcode skip) mode. Runs on the reference clock and
 * samples chip select, serial clock and IO lines through two flops.
 * Assumes the host holds each serial clock half period for at least
 * eight reference clocks and supplies read bytes on i_mem_data for
 * the address on o_mem_addr in the same cycle.
 */
// How it works
// - Dual read takes address, returns data on two lines
// - Mode byte follows address; low nibble ignored
// - Skip code makes next dual read start with address
// - Skip code makes next quad read start with address
// - Skip mode takes address from first clock
// - Other skip-select values return to opcode decoding
// - Host exits 24-bit dual skip with sixteen ones on line zero
// - Host exits quad skip with eight ones on line zero
// - Host releases lines one reference clock after the falling edge that ends the mode bits
// - Four-byte dual read always takes 32-bit address
// - Four-byte dual read refused in four-line command mode
// - Quad read uses four lines, four dummy clocks
// - Quad read needs quad lines enable bit set
`timescale 1ns/1ps
`include "dqr_defines.svh"
module dqr_dev_end (
    input  wire logic             i_ref_clk,
    input  wire logic             i_sys_rst,
    dqr_if.dev                    link,
    input  wire logic             i_quad_lines_enable_bit,
    input  wire logic             i_quad_cmd_mode,
    input  wire dqr_pkg::dqr_byte_t i_mem_data,
    output logic [31:0]           o_mem_addr,
    output logic                  o_skip_active,
    output logic                  o_busy,
    output logic                  o_refused
);
    import dqr_pkg::*;

    // ==========================================================
    // Pin synchronisers and edge detect
    logic [5:0]  sync1_r;
    logic [5:0]  sync2_r;
    logic        sclk_d_r;
    wire  logic  cs_s    = sync2_r[5];
    wire  logic  sclk_s  = sync2_r[4];
    wire  logic [3:0] io_s = sync2_r[3:0];
    wire  logic  rise    = sclk_s & ~sclk_d_r;
    wire  logic  fall    = ~sclk_s & sclk_d_r;

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sync1_r  <= 6'h2f;
            sync2_r  <= 6'h2f;
            sclk_d_r <= 1'b0;
        end else begin
            sync1_r  <= {link.cs_n, link.sclk, link.io};
            sync2_r  <= sync1_r;
            sclk_d_r <= sclk_s;
        end
    end

    // ==========================================================
    // State
    dqr_dev_st_t st_r, st_nxt;
    logic [4:0]  cnt_r, cnt_nxt;
    logic [31:0] sh_r, sh_nxt;
    logic [7:0]  cmd_r, cmd_nxt;
    logic        skip_r, skip_nxt;
    logic [7:0]  skip_cmd_r, skip_cmd_nxt;
    logic [31:0] addr_r, addr_nxt;
    logic [7:0]  dout_r, dout_nxt;
    logic [1:0]  bcnt_r, bcnt_nxt;
    logic [3:0]  io_o_r, io_o_nxt;
    logic [3:0]  io_oe_n_r, io_oe_n_nxt;
    logic        refused_r, refused_nxt;

    // ==========================================================
    // Decode
    wire logic is_quad   = (cmd_r == `DQR_OP_QUAD_IO);
    wire logic is_addr32 = (cmd_r == `DQR_OP_DUAL_IO4B);
    wire logic wide_in   = (st_r == D_OPC) ? i_quad_cmd_mode : is_quad;
    wire logic dual_in   = (st_r != D_OPC) & ~is_quad;
    wire logic [31:0] sh_in = wide_in ? {sh_r[27:0], io_s}
                            : (dual_in ? {sh_r[29:0], io_s[1:0]}
                                       : {sh_r[30:0], io_s[0]});
    wire logic [4:0] opc_len  = i_quad_cmd_mode ? `DQR_OPC_CLKS_QPI : `DQR_OPC_CLKS_SPI;
    wire logic [4:0] addr_len = is_quad ? `DQR_ADDR_CLKS_Q24
                              : (is_addr32 ? `DQR_ADDR_CLKS_D32
                                           : `DQR_ADDR_CLKS_D24);
    wire logic [4:0] mode_len = is_quad ? `DQR_MODE_CLKS_QUAD : `DQR_MODE_CLKS_DUAL;
    wire logic [1:0] byte_end = is_quad ? `DQR_BYTE_CLKS_QUAD : `DQR_BYTE_CLKS_DUAL;
    wire logic [4:0] cnt_inc  = cnt_r + 5'h01;

    // Opcode acceptance for a freshly decoded or a remembered command
    function automatic logic op_ok(input logic [7:0] op);
        op_ok = (op == `DQR_OP_DUAL_IO)
              | ((op == `DQR_OP_DUAL_IO4B) & ~i_quad_cmd_mode)
              | ((op == `DQR_OP_QUAD_IO) & i_quad_lines_enable_bit);
    endfunction : op_ok

    wire logic new_op_ok  = op_ok(sh_in[7:0]);
    wire logic skip_op_ok = op_ok(skip_cmd_r);
    wire logic [7:0] fetch_byte = (bcnt_r == 2'h0) ? i_mem_data : dout_r;

    // ==========================================================
    // Next state
    always_comb begin
        st_nxt       = st_r;
        cnt_nxt      = cnt_r;
        sh_nxt       = sh_r;
        cmd_nxt      = cmd_r;
        skip_nxt     = skip_r;
        skip_cmd_nxt = skip_cmd_r;
        addr_nxt     = addr_r;
        dout_nxt     = dout_r;
        bcnt_nxt     = bcnt_r;
        io_o_nxt     = io_o_r;
        io_oe_n_nxt  = io_oe_n_r;
        refused_nxt  = refused_r;
        if (cs_s) begin
            st_nxt      = D_IDLE;
            cnt_nxt     = 5'h00;
            bcnt_nxt    = 2'h0;
            io_oe_n_nxt = 4'hf;
        end else begin
            unique case (st_r)
                D_IDLE: begin
                    refused_nxt = 1'b0;
                    cnt_nxt     = 5'h00;
                    if (skip_r) begin
                        // Frame opens straight into the address
                        cmd_nxt     = skip_cmd_r;
                        st_nxt      = skip_op_ok ? D_ADDR : D_IGNORE;
                        refused_nxt = ~skip_op_ok;
                    end else begin
                        st_nxt = D_OPC;
                    end
                end
                D_OPC: if (rise) begin
                    sh_nxt  = sh_in;
                    cnt_nxt = cnt_inc;
                    if (cnt_inc == opc_len) begin
                        cnt_nxt     = 5'h00;
                        cmd_nxt     = sh_in[7:0];
                        st_nxt      = new_op_ok ? D_ADDR : D_IGNORE;
                        refused_nxt = ~new_op_ok;
                    end
                end
                D_ADDR: if (rise) begin
                    sh_nxt  = sh_in;
                    cnt_nxt = cnt_inc;
                    if (cnt_inc == addr_len) begin
                        cnt_nxt  = 5'h00;
                        addr_nxt = is_addr32 ? sh_in : {8'h00, sh_in[23:0]};
                        st_nxt   = D_MODE;
                    end
                end
                D_MODE: if (rise) begin
                    sh_nxt  = sh_in;
                    cnt_nxt = cnt_inc;
                    if (cnt_inc == mode_len) begin
                        cnt_nxt      = 5'h00;
                        // Only the select bits matter, low nibble dropped
                        skip_nxt     = (sh_in[5:4] == `DQR_SKIP_CODE);
                        skip_cmd_nxt = cmd_r;
                        bcnt_nxt     = 2'h0;
                        st_nxt       = is_quad ? D_DUMMY : D_DATA;
                    end
                end
                D_DUMMY: if (rise) begin
                    cnt_nxt = cnt_inc;
                    if (cnt_inc == `DQR_DUMMY_CLKS_QUAD) begin
                        cnt_nxt = 5'h00;
                        st_nxt  = D_DATA;
                    end
                end
                D_DATA: if (fall) begin
                    // Data leaves on falling edges, MSB first
                    if (is_quad) begin
                        io_oe_n_nxt = 4'h0;
                        io_o_nxt    = fetch_byte[7:4];
                        dout_nxt    = {fetch_byte[3:0], 4'h0};
                    end else begin
                        io_oe_n_nxt = 4'hc;
                        io_o_nxt    = {2'h0, fetch_byte[7:6]};
                        dout_nxt    = {fetch_byte[5:0], 2'h0};
                    end
                    if (bcnt_r == 2'h0) begin
                        addr_nxt = addr_r + 32'h1;
                    end
                    bcnt_nxt = (bcnt_r == byte_end) ? 2'h0 : bcnt_r + 2'h1;
                end
                D_IGNORE: begin
                    io_oe_n_nxt = 4'hf;
                end
                default: st_nxt = D_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_r       <= D_IDLE;
            cnt_r      <= 5'h00;
            sh_r       <= 32'h0;
            cmd_r      <= 8'h00;
            skip_r     <= 1'b0;
            skip_cmd_r <= 8'h00;
            addr_r     <= 32'h0;
            dout_r     <= 8'h00;
            bcnt_r     <= 2'h0;
            io_o_r     <= 4'h0;
            io_oe_n_r  <= 4'hf;
            refused_r  <= 1'b0;
        end else begin
            st_r       <= st_nxt;
            cnt_r      <= cnt_nxt;
            sh_r       <= sh_nxt;
            cmd_r      <= cmd_nxt;
            skip_r     <= skip_nxt;
            skip_cmd_r <= skip_cmd_nxt;
            addr_r     <= addr_nxt;
            dout_r     <= dout_nxt;
            bcnt_r     <= bcnt_nxt;
            io_o_r     <= io_o_nxt;
            io_oe_n_r  <= io_oe_n_nxt;
            refused_r  <= refused_nxt;
        end
    end

    // ==========================================================
    // Outputs
    assign link.d_io_o    = io_o_r;
    assign link.d_io_oe_n = io_oe_n_r;
    assign o_mem_addr     = addr_r;
    assign o_skip_active  = skip_r;
    assign o_busy         = (st_r != D_IDLE);
    assign o_refused      = refused_r;

endmodule : dqr_dev_end

// ==== pkg/dqr_defines.svh ====
/*
 * Constants for the dual/quad I/O read link: opcodes, phase lengths
 * counted in serial clocks, and the host's serial clock divider.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef DQR_DEFINES_SVH
`define DQR_DEFINES_SVH

// ==========================================================
// Opcodes
`define DQR_OP_DUAL_IO      8'hbb
`define DQR_OP_DUAL_IO4B    8'hbc
`define DQR_OP_QUAD_IO      8'heb

// ==========================================================
// Phase lengths in serial clocks (byte lengths minus one) and the skip code
`define DQR_OPC_CLKS_SPI    5'h08
`define DQR_OPC_CLKS_QPI    5'h02
`define DQR_ADDR_CLKS_D24   5'h0c
`define DQR_ADDR_CLKS_D32   5'h10
`define DQR_ADDR_CLKS_Q24   5'h06
`define DQR_MODE_CLKS_DUAL  5'h04
`define DQR_MODE_CLKS_QUAD  5'h02
`define DQR_DUMMY_CLKS_QUAD 5'h04
`define DQR_BYTE_CLKS_DUAL  2'h3
`define DQR_BYTE_CLKS_QUAD  2'h1
`define DQR_EXIT_CLKS_DUAL  5'h10
`define DQR_EXIT_CLKS_QUAD  5'h08
`define DQR_SKIP_CODE       2'h2

// ==========================================================
// Host serial clock: half period in reference clocks, minus one
`define DQR_SCLK_HALF_M1    4'h7

`endif

// ==== pkg/dqr_pkg.sv ====
/*
 * Types shared by both ends of the dual/quad I/O read link.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package dqr_pkg;

    typedef logic [7:0] dqr_byte_t;

    typedef enum logic [2:0] {
        D_IDLE   = 3'h0,
        D_OPC    = 3'h1,
        D_ADDR   = 3'h2,
        D_MODE   = 3'h3,
        D_DUMMY  = 3'h4,
        D_DATA   = 3'h5,
        D_IGNORE = 3'h6
    } dqr_dev_st_t;

    typedef enum logic [2:0] {
        H_IDLE = 3'h0,
        H_LOAD = 3'h1,
        H_RUN  = 3'h2,
        H_END  = 3'h3,
        H_GAP  = 3'h4
    } dqr_host_st_t;

endpackage : dqr_pkg

// ==== pkg/dqr_if.sv ====
/*
 * Serial link between host controller and flash command logic.
 * Resolves the four shared IO lines from both ends' enables; an
 * undriven line reads high as with a pull-up.
 */
`timescale 1ns/1ps
interface dqr_if;
    logic       cs_n;
    logic       sclk;
    logic [3:0] h_io_o;
    logic [3:0] h_io_oe_n;
    logic [3:0] d_io_o;
    logic [3:0] d_io_oe_n;
    logic [3:0] io;

    // ==========================================================
    // Line resolution
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            io[i] = !h_io_oe_n[i] ? h_io_o[i] : (!d_io_oe_n[i] ? d_io_o[i] : 1'b1);
        end
    end

    modport dev  (input cs_n, sclk, io, output d_io_o, d_io_oe_n);
    modport host (output cs_n, sclk, h_io_o, h_io_oe_n, input io);
endinterface : dqr_if

// ==== logic/dqr_host_end.sv ====
/*
 * Host controller end: frames one read (or a skip-exit sequence) per
 * start pulse, makes the serial clock by dividing the reference clock
 * and returns read bytes. Assumes the flash end on the same link.
 */
`timescale 1ns/1ps
`include "dqr_defines.svh"
module dqr_host_end (
    input  wire logic               i_ref_clk,
    input  wire logic               i_sys_rst,
    dqr_if.host                     link,
    input  wire logic               i_start,
    input  wire dqr_pkg::dqr_byte_t i_cmd,
    input  wire logic [31:0]        i_addr,
    input  wire dqr_pkg::dqr_byte_t i_mode,
    input  wire logic               i_skip_opcode,
    input  wire logic               i_exit_skip,
    input  wire logic               i_quad_cmd_mode,
    input  wire dqr_pkg::dqr_byte_t i_nbytes,
    output logic                    o_busy,
    output dqr_pkg::dqr_byte_t      o_rd_data,
    output logic                    o_rd_valid,
    output logic                    o_done
);
    import dqr_pkg::*;

    // ==========================================================
    // Frame plan from the request
    wire logic        quad = (i_cmd == `DQR_OP_QUAD_IO);
    wire logic        a32  = (i_cmd == `DQR_OP_DUAL_IO4B);
    wire logic [10:0] opc  = i_exit_skip ? {6'h0, quad ? `DQR_EXIT_CLKS_QUAD
                                                       : `DQR_EXIT_CLKS_DUAL}
                           : (i_skip_opcode ? 11'h0
                              : {6'h0, i_quad_cmd_mode ? `DQR_OPC_CLKS_QPI
                                                       : `DQR_OPC_CLKS_SPI});
    wire logic [10:0] adc  = i_exit_skip ? 11'h0 : {6'h0, quad ? `DQR_ADDR_CLKS_Q24
                           : (a32 ? `DQR_ADDR_CLKS_D32 : `DQR_ADDR_CLKS_D24)};
    wire logic [10:0] mdc  = i_exit_skip ? 11'h0
                           : {6'h0, quad ? `DQR_MODE_CLKS_QUAD : `DQR_MODE_CLKS_DUAL};
    wire logic [10:0] dmc  = (i_exit_skip | ~quad) ? 11'h0 : {6'h0, `DQR_DUMMY_CLKS_QUAD};
    wire logic [10:0] dtc  = i_exit_skip ? 11'h0
                           : (quad ? {2'h0, i_nbytes, 1'b0} : {1'b0, i_nbytes, 2'h0});
    wire logic [39:0] txl  = a32 ? {i_addr, i_mode} : {i_addr[23:0], i_mode, 8'h00};

    // ==========================================================
    // State
    dqr_host_st_t st_r;
    logic [3:0]   dv_r;
    logic         sclk_r;
    logic         cs_n_r;
    logic [10:0]  k_r;
    logic [10:0]  b1_r, b2_r, b3_r, b4_r, tot_r;
    logic [7:0]   op_r;
    logic [39:0]  tx_r;
    logic         quad_r, qpi_r, exit_r;
    logic [3:0]   io_o_r, oe_n_r;
    logic [3:0]   s1_r, s2_r;
    logic [7:0]   rx_r;
    logic [1:0]   rb_r;
    logic [7:0]   rd_r;
    logic         rd_v_r, done_r;

    wire logic half_end = (dv_r == `DQR_SCLK_HALF_M1);
    wire logic in_op    = (k_r < b1_r);
    wire logic in_am    = (k_r < b3_r);
    wire logic in_data  = (k_r >= b4_r) & ~exit_r;
    wire logic [7:0] rx_in = quad_r ? {rx_r[3:0], s2_r} : {rx_r[5:0], s2_r[1:0]};
    wire logic [1:0] rb_end = quad_r ? `DQR_BYTE_CLKS_QUAD : `DQR_BYTE_CLKS_DUAL;

    // ==========================================================
    // Sequencer
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_r <= H_IDLE;  dv_r <= 4'h0;   sclk_r <= 1'b0; cs_n_r <= 1'b1;
            k_r  <= 11'h0;   b1_r <= 11'h0;  b2_r <= 11'h0;  b3_r <= 11'h0;
            b4_r <= 11'h0;   tot_r <= 11'h0; op_r <= 8'h00;  tx_r <= 40'h0;
            quad_r <= 1'b0;  qpi_r <= 1'b0;  exit_r <= 1'b0;
            io_o_r <= 4'h0;  oe_n_r <= 4'hf; s1_r <= 4'hf;   s2_r <= 4'hf;
            rx_r <= 8'h00;   rb_r <= 2'h0;   rd_r <= 8'h00;
            rd_v_r <= 1'b0;  done_r <= 1'b0;
        end else begin
            s1_r   <= link.io;
            s2_r   <= s1_r;
            rd_v_r <= 1'b0;
            done_r <= 1'b0;
            unique case (st_r)
                H_IDLE: if (i_start) begin
                    b1_r <= opc;
                    b2_r <= opc + adc;
                    b3_r <= opc + adc + mdc;
                    b4_r <= opc + adc + mdc + dmc;
                    tot_r <= opc + adc + mdc + dmc + dtc;
                    op_r <= i_cmd;  tx_r <= txl;     quad_r <= quad;
                    qpi_r <= i_quad_cmd_mode;        exit_r <= i_exit_skip;
                    k_r <= 11'h0;   dv_r <= 4'h0;    rb_r <= 2'h0;
                    cs_n_r <= 1'b0;
                    st_r <= H_LOAD;
                end
                H_LOAD: begin
                    dv_r <= dv_r + 4'h1;
                    st_r <= H_RUN;
                    if (in_op & qpi_r & ~exit_r) begin
                        io_o_r <= op_r[7:4];  oe_n_r <= 4'h0;  op_r <= {op_r[3:0], 4'h0};
                    end else if (in_op) begin
                        // Exit sequence keeps line zero high throughout
                        io_o_r <= {3'h0, exit_r | op_r[7]};
                        oe_n_r <= 4'he;
                        op_r   <= {op_r[6:0], 1'b0};
                    end else if (in_am & quad_r) begin
                        io_o_r <= tx_r[39:36]; oe_n_r <= 4'h0; tx_r <= {tx_r[35:0], 4'h0};
                    end else if (in_am) begin
                        io_o_r <= {2'h0, tx_r[39:38]}; oe_n_r <= 4'hc;
                        tx_r   <= {tx_r[37:0], 2'h0};
                    end else begin
                        oe_n_r <= 4'hf;
                    end
                end
                H_RUN: begin
                    dv_r <= half_end ? 4'h0 : dv_r + 4'h1;
                    if (half_end) begin
                        sclk_r <= ~sclk_r;
                        if (~sclk_r & in_data) begin
                            rx_r <= rx_in;
                            rb_r <= (rb_r == rb_end) ? 2'h0 : rb_r + 2'h1;
                            if (rb_r == rb_end) begin
                                rd_r   <= rx_in;
                                rd_v_r <= 1'b1;
                            end
                        end else if (sclk_r) begin
                            k_r  <= k_r + 11'h1;
                            st_r <= (k_r + 11'h1 == tot_r) ? H_END : H_LOAD;
                        end
                    end
                end
                H_END: begin
                    oe_n_r <= 4'hf;
                    dv_r   <= half_end ? 4'h0 : dv_r + 4'h1;
                    if (half_end) begin
                        cs_n_r <= 1'b1;
                        st_r   <= H_GAP;
                    end
                end
                H_GAP: begin
                    dv_r <= half_end ? 4'h0 : dv_r + 4'h1;
                    if (half_end) begin
                        done_r <= 1'b1;
                        st_r   <= H_IDLE;
                    end
                end
                default: st_r <= H_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Outputs
    assign link.cs_n      = cs_n_r;
    assign link.sclk      = sclk_r;
    assign link.h_io_o    = io_o_r;
    assign link.h_io_oe_n = oe_n_r;
    assign o_busy         = (st_r != H_IDLE);
    assign o_rd_data      = rd_r;
    assign o_rd_valid     = rd_v_r;
    assign o_done         = done_r;

endmodule : dqr_host_end

// ==== sim/dqr_link_props.sv ====
/*
 * Link checker for the dual/quad I/O read link between host and flash.
 * Assumes the signals of dqr_if and the reference clock and reset.
 */
`timescale 1ns/1ps
module dqr_link_props (
    input  wire logic       i_ref_clk,
    input  wire logic       i_sys_rst,
    input  wire logic       cs_n,
    input  wire logic       sclk,
    input  wire logic [3:0] h_io_o,
    input  wire logic [3:0] h_io_oe_n,
    input  wire logic [3:0] d_io_o,
    input  wire logic [3:0] d_io_oe_n,
    input  wire logic [3:0] io
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);

    // ==========================================================
    // Steps of a frame
    sequence s_frame_end;
        $rose(cs_n);
    endsequence
    sequence s_lines_free;
        ##[0:4] (d_io_oe_n == 4'hf);
    endsequence
    sequence s_clk_high;
        sclk [*8] ##1 !sclk;
    endsequence

    // ==========================================================
    // Properties
    chk_no_contention: assert property ((h_io_oe_n | d_io_oe_n) == 4'hf)
        else $error("host and flash drive one line together");
    chk_drive_shape: assert property (d_io_oe_n inside {4'hf, 4'hc, 4'h0})
        else $error("flash drives an odd set of lines");
    chk_data_on_low: assert property ((d_io_oe_n != 4'hf) && $changed(d_io_o) |-> !sclk)
        else $error("flash data changed while serial clock high");
    chk_drive_start: assert property ($fell(d_io_oe_n[0]) |-> !sclk && !cs_n)
        else $error("flash began driving outside a low clock phase");
    chk_line_release: assert property (s_frame_end |-> s_lines_free)
        else $error("flash kept driving after chip select rose");
    chk_sclk_half: assert property ($rose(sclk) |-> s_clk_high)
        else $error("serial clock high phase not eight cycles");
    chk_cs_setup: assert property ($fell(cs_n) |-> (!sclk) [*8])
        else $error("serial clock rose too soon after chip select");
    chk_idle_clock: assert property (cs_n |-> !sclk)
        else $error("serial clock moved outside a frame");
endmodule : dqr_link_props

// ==== sim/dual_quad_io_read_cmds_bench.sv ====
/*
 * Bench joining host and flash ends over dqr_if; reads and skip modes.
 * Assumes the design files and dqr_link_props are compiled first.
 */
`timescale 1ns/1ps
`include "dqr_defines.svh"
module dual_quad_io_read_cmds_bench;
    import dqr_pkg::*;
    logic        i_ref_clk = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic        start = 1'b0, skip = 1'b0, ex = 1'b0, qmode = 1'b0, qe = 1'b1;
    dqr_byte_t   cmd = 8'h00, mode = 8'h00, nb = 8'h00, mem_data, rd_data;
    logic [31:0] addr = 32'h0, mem_addr;
    logic        skip_act, dbusy, refused, hbusy, rd_valid, done;
    int          fails = 0, cmp_count = 0;

    dqr_if dqr_if_inst ();
    always #50 i_ref_clk = ~i_ref_clk;
    assign mem_data = mem_addr[7:0] ^ mem_addr[15:8] ^ mem_addr[31:24];

    dqr_dev_end dqr_dev_end_inst (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
        .link(dqr_if_inst.dev), .i_quad_lines_enable_bit(qe), .i_quad_cmd_mode(qmode),
        .i_mem_data(mem_data), .o_mem_addr(mem_addr), .o_skip_active(skip_act),
        .o_busy(dbusy), .o_refused(refused));
    dqr_host_end dqr_host_end_inst (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
        .link(dqr_if_inst.host), .i_start(start), .i_cmd(cmd), .i_addr(addr),
        .i_mode(mode), .i_skip_opcode(skip), .i_exit_skip(ex), .i_quad_cmd_mode(qmode),
        .i_nbytes(nb), .o_busy(hbusy), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
        .o_done(done));
    dqr_link_props dqr_link_props_inst (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
        .cs_n(dqr_if_inst.cs_n), .sclk(dqr_if_inst.sclk), .h_io_o(dqr_if_inst.h_io_o),
        .h_io_oe_n(dqr_if_inst.h_io_oe_n), .d_io_o(dqr_if_inst.d_io_o),
        .d_io_oe_n(dqr_if_inst.d_io_oe_n), .io(dqr_if_inst.io));

    // ==========================================================
    // Compares and closing
    task automatic cmp8(input string nm, input dqr_byte_t e, input dqr_byte_t g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp8
    task automatic cmp1(input string nm, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %b seen %b", nm, e, g);
        end
    endtask : cmp1
    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : test_done

    // ==========================================================
    // One host frame; checks every byte and the byte count
    task automatic frame(input dqr_byte_t c, input logic [31:0] a, input dqr_byte_t m,
                         input logic sk, input logic x, input dqr_byte_t n);
        logic [31:0] ea;
        dqr_byte_t   got;
        int          t;
        ea = (c == `DQR_OP_DUAL_IO4B) ? a : {8'h00, a[23:0]};
        got = 8'h00;
        t = 0;
        @(posedge i_ref_clk);
        start <= 1'b1;
        cmd <= c;
        addr <= a;
        mode <= m;
        skip <= sk;
        ex <= x;
        nb <= n;
        @(posedge i_ref_clk);
        start <= 1'b0;
        while (done !== 1'b1 && t < 5000) begin
            @(posedge i_ref_clk);
            #1;
            t++;
            if (rd_valid === 1'b1) begin
                cmp8("read byte", ea[7:0] ^ ea[15:8] ^ ea[31:24], rd_data);
                ea = ea + 32'h1;
                got++;
            end
        end
        cmp1("frame done", 1'b1, done);
        cmp1("flash busy", 1'b0, dbusy);
        cmp1("host busy", 1'b0, hbusy);
        cmp8("byte count", n, got);
    endtask : frame

    // ==========================================================
    // Scenarios
    task automatic t_dual_plain;
        frame(`DQR_OP_DUAL_IO, 32'h00123456, 8'h00, 1'b0, 1'b0, 8'h03);
        cmp1("skip flag", 1'b0, skip_act);
    endtask : t_dual_plain
    task automatic t_dual_skip;
        frame(`DQR_OP_DUAL_IO, 32'h00fffffe, 8'h2f, 1'b0, 1'b0, 8'h02);
        cmp1("skip flag", 1'b1, skip_act);
        frame(`DQR_OP_DUAL_IO, 32'h00000100, 8'h20, 1'b1, 1'b0, 8'h01);
        cmp1("skip flag", 1'b1, skip_act);
        frame(`DQR_OP_DUAL_IO, 32'h00abcdef, 8'h1f, 1'b1, 1'b0, 8'h02);
        cmp1("skip flag", 1'b0, skip_act);
        frame(`DQR_OP_DUAL_IO, 32'h00000010, 8'h00, 1'b0, 1'b0, 8'h01);
    endtask : t_dual_skip
    task automatic t_quad_skip;
        frame(`DQR_OP_QUAD_IO, 32'h00345678, 8'ha5, 1'b0, 1'b0, 8'h04);
        cmp1("skip flag", 1'b1, skip_act);
        frame(`DQR_OP_QUAD_IO, 32'h00000042, 8'h20, 1'b1, 1'b0, 8'h02);
        frame(`DQR_OP_QUAD_IO, 32'h0, 8'h00, 1'b0, 1'b1, 8'h00);
        cmp1("skip flag", 1'b0, skip_act);
    endtask : t_quad_skip
    task automatic t_refuse;
        qe <= 1'b0;
        frame(`DQR_OP_QUAD_IO, 32'h00000010, 8'h00, 1'b0, 1'b0, 8'h00);
        cmp1("refused", 1'b1, refused);
        qe <= 1'b1;
        qmode <= 1'b1;
        frame(`DQR_OP_DUAL_IO4B, 32'h00000010, 8'h00, 1'b0, 1'b0, 8'h00);
        cmp1("refused", 1'b1, refused);
        qmode <= 1'b0;
    endtask : t_refuse
    task automatic t_wide;
        frame(`DQR_OP_DUAL_IO4B, 32'h89abcdef, 8'h20, 1'b0, 1'b0, 8'h02);
        cmp1("refused", 1'b0, refused);
        cmp1("skip flag", 1'b1, skip_act);
        frame(`DQR_OP_DUAL_IO4B, 32'h01020304, 8'h30, 1'b1, 1'b0, 8'h01);
        cmp1("skip flag", 1'b0, skip_act);
        frame(`DQR_OP_DUAL_IO, 32'h00000020, 8'h20, 1'b0, 1'b0, 8'h01);
        cmp1("skip flag", 1'b1, skip_act);
        frame(`DQR_OP_DUAL_IO, 32'h0, 8'h00, 1'b0, 1'b1, 8'h00);
        cmp1("skip flag", 1'b0, skip_act);
    endtask : t_wide
    task automatic t_reset;
        frame(`DQR_OP_DUAL_IO, 32'h00000030, 8'h20, 1'b0, 1'b0, 8'h01);
        cmp1("skip flag", 1'b1, skip_act);
        i_sys_rst <= 1'b1;
        repeat (5) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        cmp1("skip flag", 1'b0, skip_act);
        repeat (4) @(posedge i_ref_clk);
        frame(`DQR_OP_DUAL_IO, 32'h00000040, 8'h00, 1'b0, 1'b0, 8'h01);
    endtask : t_reset

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        repeat (5) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        repeat (4) @(posedge i_ref_clk);
        t_dual_plain();
        t_dual_skip();
        t_quad_skip();
        t_refuse();
        t_wide();
        t_reset();
        test_done();
    end
    initial begin
        #3000000;
        fails++;
        test_done();
    end
endmodule : dual_quad_io_read_cmds_bench
